//--- hw/ccms_regs.svh
`ifndef CCMS_REGS_SVH
`define CCMS_REGS_SVH
// register byte offsets
`define A_CTRL    10'h000
`define A_CTXA    10'h004
`define A_CTXB    10'h008
`define A_STAT    10'h00C
`define A_AE      10'h010
`define A_AEWIN   10'h014
`define A_AWB     10'h018
`define A_FLK     10'h01C
`define A_BLK     10'h020
// field positions
`define CTRL_CMD   0
`define CTRL_VIDEO 8
`define CTRL_NF    7:4
`define AE_TGT     9:0
`define AE_DB      17:10
`define AE_SPD     20:18
`define AWB_LO     7:0
`define AWB_HI     15:8
`define AWB_SPD    18:16
`define AWB_TGT    31:24
`define FLK_P50    11:0
`define FLK_P60    23:12
`define FLK_EN     24
`define FLK_AUTO   25
// reset values
`define RST_CTRL   32'h0000_0010
`define RST_CTXA   32'h0400_8008
`define RST_CTXB   32'h2064_04B0
`define RST_AE     32'h0008_4200
`define RST_AEWIN  16'hFFFF
`define RST_AWB    32'h4001_8020
`define RST_FLK    32'h0105_3064
`define RST_EXP    12'h100
`define RST_GAIN   8'h40
// frame counts
`define ADJ_FRAMES 4'h2
`define FLK_ALT    3'h4
`endif

//--- hw/ccms_pkg.sv
package ccms_pkg;
   // mode sequencer states, gray along preview -> adjust -> capture
   typedef enum logic [1:0] {
      ST_PREV = 2'b00,
      ST_ADJ  = 2'b01,
      ST_CAP  = 2'b11,
      ST_VID  = 2'b10
   } mode_t;
   // one parameter set
   typedef struct packed {
      logic [7:0]  blank;
      logic [11:0] cols;
      logic [11:0] rows;
   } ctx_t;
   // converter sample from the column chain
   typedef struct packed {
      logic       black;
      logic [9:0] data;
   } adc_t;
   // corrected output sample
   typedef struct packed {
      logic       sof;
      logic [9:0] data;
   } pix_t;
endpackage

//--- hw/camera_context_mode_sequencer.sv
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "ccms_regs.svh"

// What this block does
// - host reaches every register and table word
// - two parameter sets, switched by command
// - first set is low power preview
// - snapshot: adjust, compress, capture, return
// - video: host updates set, then commands
// - video uses smooth continuous exposure
// - further command returns video to preview
// - sixteen windows in four by four grid
// - preview exposure, center weighted windows
// - averaged, tunable speed, target, window
// - snapshot classifies scene, adjusts target
// - colour gains bounded, speed programmable
// - integration is multiple of light period
// - below one period flicker not avoided
// - rows reset, later read, gap is exposure
// - offset, gain, ten bit sample out
// - black pixels drive offset correction
module camera_context_mode_sequencer (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic                  hreadyout,
   output logic [31:0]           hrdata,
   output logic                  hresp,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire ccms_pkg::adc_t   in_pix,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output ccms_pkg::pix_t        out_pix,
   output logic                  row_strobe,
   output logic [11:0]           row_rd_addr,
   output logic [11:0]           row_rst_addr,
   output logic                  active_ctx,
   output logic                  jpeg_en,
   output logic                  ae_smooth
);
   logic [9:0]           aq_r;
   logic                 wq_r, rq_r, wr_en, acc, cmd;
   logic [31:0]          ctrl_r, ae_r, awb_r, flk_r, rdata_c;
   logic [15:0]          aewin_r;
   ccms_pkg::ctx_t       ctxa_r, ctxb_r, cur_r;
   logic [31:0]          tbl [0:127];
   ccms_pkg::mode_t      st_r, st_nxt;
   logic                 pend_r, frame_end, line_tick, ae_go_r, sof_pend_r;
   logic [3:0]           frm_r, nf;
   logic [12:0]          col_r, line_last;
   logic [11:0]          rd_row_r, rd_nxt, pcol_r, exp_r, app_r, fq_r, per;
   logic [12:0]          rst_sum;
   logic [11:0]          app_eff;
   logic [9:0]           blk_r, sub_c, corr;
   logic [17:0]          prod;
   logic [7:0]           gain_r;
   logic [8:0]           gnxt;
   logic                 take, push, pop, sk_v_r;
   ccms_pkg::pix_t       sk_r, pin;
   logic [3:0]           win_idx;
   logic [23:0]          acc_r [0:15];
   logic [23:0]          win_r [0:15];
   logic [28:0]          tot, prev_tot_r;
   logic [5:0]           wsum;
   logic [23:0]          mx, mn;
   logic [19:0]          npw;
   logic [10:0]          lvl_lo, lvl_hi;
   logic [9:0]           tgt_r;
   logic [36:0]          ref_lo, ref_hi;
   logic                 dark, bright, dir_r, sel60_r;
   logic [2:0]           alt_r;
   logic signed [4:0]    vote_r, thr;
   logic [11:0]          step, exp_up, exp_dn;

   // bus address phase capture
   assign acc   = hsel & htrans[1] & hready;
   assign wr_en = wq_r & hready;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aq_r <= 10'h000;
         wq_r <= 1'b0;
         rq_r <= 1'b0;
      end else if (hready) begin
         aq_r <= haddr[9:0];
         wq_r <= acc & hwrite;
         rq_r <= acc & ~hwrite;
      end
   end

   // reads take one wait cycle, data comes from a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hrdata    <= 32'h0000_0000;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= ~(acc & ~hwrite);
         if (rq_r & ~hreadyout)
            hrdata <= rdata_c;
      end
   end

   // read mux
   always_comb begin
      unique case (aq_r)
         `A_CTRL:  rdata_c = ctrl_r;
         `A_CTXA:  rdata_c = ctxa_r;
         `A_CTXB:  rdata_c = ctxb_r;
         `A_STAT:  rdata_c = {4'h0, app_r, 10'h000, sel60_r, ae_smooth, jpeg_en, st_r, active_ctx};
         `A_AE:    rdata_c = ae_r;
         `A_AEWIN: rdata_c = {16'h0000, aewin_r};
         `A_AWB:   rdata_c = awb_r;
         `A_FLK:   rdata_c = flk_r;
         `A_BLK:   rdata_c = {14'h0000, gain_r, blk_r};
         default:  rdata_c = aq_r[9] ? tbl[aq_r[8:2]] : 32'h0000_0000;
      endcase
   end

   // control register writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r  <= `RST_CTRL;
         ctxa_r  <= `RST_CTXA;
         ctxb_r  <= `RST_CTXB;
         ae_r    <= `RST_AE;
         aewin_r <= `RST_AEWIN;
         awb_r   <= `RST_AWB;
         flk_r   <= `RST_FLK;
      end else if (wr_en) begin
         unique case (aq_r)
            `A_CTRL:  ctrl_r  <= {hwdata[31:1], 1'b0};
            `A_CTXA:  ctxa_r  <= hwdata;
            `A_CTXB:  ctxb_r  <= hwdata;
            `A_AE:    ae_r    <= hwdata;
            `A_AEWIN: aewin_r <= hwdata[15:0];
            `A_AWB:   awb_r   <= hwdata;
            `A_FLK:   flk_r   <= hwdata;
            default:  ;
         endcase
      end
   end

   // quantization, huffman and colour matrix words
   always_ff @(posedge hclk) begin
      if (wr_en && aq_r[9])
         tbl[aq_r[8:2]] <= hwdata;
   end

   // pending context change, set wins over consume
   assign cmd = wr_en && aq_r == `A_CTRL && hwdata[`CTRL_CMD];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         pend_r <= 1'b0;
      else if (cmd)
         pend_r <= 1'b1;
      else if (frame_end)
         pend_r <= 1'b0;
   end

   // mode sequencer next state, moves only on frame end
   assign nf = (ctrl_r[`CTRL_NF] == 4'h0) ? 4'h1 : ctrl_r[`CTRL_NF];
   always_comb begin
      st_nxt = st_r;
      if (frame_end) begin
         unique case (st_r)
            ccms_pkg::ST_PREV: if (pend_r)
               st_nxt = ctrl_r[`CTRL_VIDEO] ? ccms_pkg::ST_VID : ccms_pkg::ST_ADJ;
            ccms_pkg::ST_ADJ:  if (frm_r == `ADJ_FRAMES - 4'h1)
               st_nxt = ccms_pkg::ST_CAP;
            ccms_pkg::ST_CAP:  if (frm_r == nf - 4'h1)
               st_nxt = ccms_pkg::ST_PREV;
            ccms_pkg::ST_VID:  if (pend_r)
               st_nxt = ccms_pkg::ST_PREV;
         endcase
      end
   end

   // state, frame count and mode outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r       <= ccms_pkg::ST_PREV;
         frm_r      <= 4'h0;
         active_ctx <= 1'b0;
         jpeg_en    <= 1'b0;
         ae_smooth  <= 1'b0;
      end else begin
         st_r       <= st_nxt;
         if (st_nxt != st_r)
            frm_r <= 4'h0;
         else if (frame_end)
            frm_r <= frm_r + 4'h1;
         active_ctx <= st_nxt != ccms_pkg::ST_PREV;
         jpeg_en    <= st_nxt == ccms_pkg::ST_CAP;
         ae_smooth  <= st_nxt == ccms_pkg::ST_VID;
      end
   end

   // line and row timing, set latched at frame end
   assign line_last = {1'b0, cur_r.cols} + {5'h00, cur_r.blank} - 13'h0001;
   assign line_tick = col_r == line_last;
   assign frame_end = line_tick && rd_row_r == cur_r.rows - 12'h001;
   assign rd_nxt    = frame_end ? 12'h000 : rd_row_r + 12'h001;
   // exposure held below one frame so the reset row stays inside the array
   assign app_eff   = (app_r >= cur_r.rows) ? cur_r.rows - 12'h001 : app_r;
   assign rst_sum   = {1'b0, rd_nxt} + {1'b0, app_eff};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur_r        <= `RST_CTXA;
         col_r        <= 13'h0000;
         rd_row_r     <= 12'h000;
         row_strobe   <= 1'b0;
         row_rd_addr  <= 12'h000;
         row_rst_addr <= 12'h000;
      end else begin
         col_r      <= line_tick ? 13'h0000 : col_r + 13'h0001;
         row_strobe <= line_tick;
         if (line_tick) begin
            rd_row_r     <= rd_nxt;
            row_rd_addr  <= rd_nxt;
            row_rst_addr <= (rst_sum >= {1'b0, cur_r.rows}) ? 12'(rst_sum - {1'b0, cur_r.rows}) : rst_sum[11:0];
         end
         if (frame_end)
            cur_r <= (st_nxt != ccms_pkg::ST_PREV) ? ctxb_r : ctxa_r;
      end
   end

   // quartile of a position within a span
   function automatic logic [1:0] quart(input logic [11:0] v, input logic [11:0] n);
      logic [11:0] q1;
      q1 = n >> 2;
      if (v < q1)
         quart = 2'h0;
      else if (v < (n >> 1))
         quart = 2'h1;
      else if (v < q1 + (n >> 1))
         quart = 2'h2;
      else
         quart = 2'h3;
   endfunction

   // offset removal and gain, saturating to ten bits
   assign take    = in_valid & in_ready;
   assign push    = take & ~in_pix.black;
   assign sub_c   = (in_pix.data > blk_r) ? in_pix.data - blk_r : 10'h000;
   assign prod    = sub_c * gain_r;
   assign corr    = (|prod[17:16]) ? 10'h3FF : prod[15:6];
   assign pin     = '{sof: sof_pend_r, data: corr};
   assign win_idx = {quart(rd_row_r, cur_r.rows), quart(pcol_r, cur_r.cols)};

   // black level tracking and column position
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         blk_r      <= 10'h000;
         pcol_r     <= 12'h000;
         sof_pend_r <= 1'b1;
      end else begin
         if (take && in_pix.black)
            blk_r <= blk_r + 10'(($signed({1'b0, in_pix.data}) - $signed({1'b0, blk_r})) >>> 3);
         if (line_tick)
            pcol_r <= 12'h000;
         else if (push)
            pcol_r <= pcol_r + 12'h001;
         if (frame_end)
            sof_pend_r <= 1'b1;
         else if (push)
            sof_pend_r <= 1'b0;
      end
   end

   // two entry buffer: head drives the port, skid catches a stall
   assign pop = out_valid & out_ready;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_valid <= 1'b0;
         out_pix   <= '0;
         sk_v_r    <= 1'b0;
         sk_r      <= '0;
         in_ready  <= 1'b0;
      end else begin
         if (!out_valid || pop) begin
            out_valid <= sk_v_r | push;
            out_pix   <= sk_v_r ? sk_r : pin;
            sk_v_r    <= sk_v_r & push;
            if (sk_v_r)
               sk_r <= pin;
            in_ready  <= ~(sk_v_r & push);
         end else begin
            if (push) begin
               sk_v_r <= 1'b1;
               sk_r   <= pin;
            end
            in_ready <= ~(sk_v_r | push);
         end
      end
   end

   // per window luminance sums, handed over at frame end
   for (genvar i = 0; i < 16; i++) begin : g_win
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            acc_r[i] <= 24'h000000;
            win_r[i] <= 24'h000000;
         end else if (frame_end) begin
            win_r[i] <= acc_r[i];
            acc_r[i] <= 24'h000000;
         end else if (push && win_idx == 4'(i)) begin
            acc_r[i] <= acc_r[i] + {14'h0000, corr};
         end
      end
   end

   // weighted total of chosen windows, centre counts double
   always_comb begin
      tot  = 29'h0;
      wsum = 6'h00;
      mx   = 24'h000000;
      mn   = 24'hFFFFFF;
      for (int i = 0; i < 16; i++) begin
         if (aewin_r[i]) begin
            if (i == 5 || i == 6 || i == 9 || i == 10) begin
               tot  = tot + {4'h0, win_r[i], 1'b0};
               wsum = wsum + 6'h02;
            end else begin
               tot  = tot + {5'h00, win_r[i]};
               wsum = wsum + 6'h01;
            end
         end
         if (win_r[i] > mx)
            mx = win_r[i];
         if (win_r[i] < mn)
            mn = win_r[i];
      end
   end

   // brightness band around the target, scaled by window area
   assign npw    = (cur_r.rows >> 2) * (cur_r.cols >> 2);
   assign lvl_lo = (tgt_r > 10'(ae_r[`AE_DB])) ? {1'b0, tgt_r - 10'(ae_r[`AE_DB])} : 11'h000;
   assign lvl_hi = {1'b0, tgt_r} + {3'h0, ae_r[`AE_DB]};
   assign ref_lo = 37'(lvl_lo) * 37'(npw) * 37'(wsum);
   assign ref_hi = 37'(lvl_hi) * 37'(npw) * 37'(wsum);
   assign dark   = {8'h00, tot} < ref_lo;
   assign bright = {8'h00, tot} > ref_hi;

   // target: host value, or scene class while adjusting for a snapshot
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tgt_r   <= 10'h200;
         ae_go_r <= 1'b0;
      end else begin
         ae_go_r <= frame_end;
         if (st_r != ccms_pkg::ST_ADJ)
            tgt_r <= ae_r[`AE_TGT];
         else if (ae_go_r && mx > {mn[21:0], 2'b00})
            tgt_r <= tgt_r + (tgt_r >> 2);
         else if (ae_go_r && {4'h0, mn} > {tgt_r, 1'b0} * {8'h00, npw})
            tgt_r <= tgt_r - (tgt_r >> 2);
      end
   end

   // exposure steps once a run of votes agrees
   assign thr    = ae_smooth ? 5'sd1 : $signed({2'b00, ae_r[`AE_SPD]}) + 5'sd1;
   assign step   = (ae_smooth || exp_r < 12'h008) ? 12'h001 : exp_r >> 3;
   assign exp_up = (exp_r + step >= cur_r.rows) ? cur_r.rows - 12'h001 : exp_r + step;
   assign exp_dn = (exp_r > step) ? exp_r - step : 12'h001;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         exp_r  <= `RST_EXP;
         vote_r <= 5'sd0;
      end else if (ae_go_r) begin
         if (dark && vote_r + 5'sd1 >= thr) begin
            exp_r  <= exp_up;
            vote_r <= 5'sd0;
         end else if (dark) begin
            vote_r <= vote_r + 5'sd1;
         end else if (bright && vote_r - 5'sd1 <= -thr) begin
            exp_r  <= exp_dn;
            vote_r <= 5'sd0;
         end else if (bright) begin
            vote_r <= vote_r - 5'sd1;
         end else begin
            vote_r <= 5'sd0;
         end
      end
   end

   // flicker: pick light period from alternating brightness
   assign per = sel60_r ? flk_r[`FLK_P60] : flk_r[`FLK_P50];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_tot_r <= 29'h0;
         dir_r      <= 1'b0;
         alt_r      <= 3'h0;
         sel60_r    <= 1'b0;
      end else if (ae_go_r) begin
         prev_tot_r <= tot;
         dir_r      <= tot > prev_tot_r;
         if (!flk_r[`FLK_AUTO] || (tot > prev_tot_r) == dir_r) begin
            alt_r <= 3'h0;
         end else if (alt_r == `FLK_ALT - 3'h1) begin
            alt_r   <= 3'h0;
            sel60_r <= ~sel60_r;
         end else begin
            alt_r <= alt_r + 3'h1;
         end
      end
   end

   // integration rounded down to whole light periods, applied per frame
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fq_r  <= 12'h000;
         app_r <= `RST_EXP;
      end else if (frame_end) begin
         app_r <= (!flk_r[`FLK_EN] || fq_r == 12'h000) ? exp_r : fq_r;
         fq_r  <= 12'h000;
      end else if (per != 12'h000 && {1'b0, fq_r} + {1'b0, per} <= {1'b0, exp_r}) begin
         fq_r <= fq_r + per;
      end
   end

   // colour gain walks to its target within host bounds
   always_comb begin
      if (gain_r < awb_r[`AWB_TGT])
         gnxt = 9'({1'b0, gain_r} + (9'h001 << awb_r[`AWB_SPD]));
      else if (gain_r > awb_r[`AWB_TGT] && {1'b0, gain_r} > (9'h001 << awb_r[`AWB_SPD]))
         gnxt = 9'({1'b0, gain_r} - (9'h001 << awb_r[`AWB_SPD]));
      else
         gnxt = {1'b0, awb_r[`AWB_TGT]};
      if (gnxt > {1'b0, awb_r[`AWB_HI]})
         gnxt = {1'b0, awb_r[`AWB_HI]};
      if (gnxt < {1'b0, awb_r[`AWB_LO]})
         gnxt = {1'b0, awb_r[`AWB_LO]};
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         gain_r <= `RST_GAIN;
      else if (ae_go_r)
         gain_r <= gnxt[7:0];
   end

   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_snap_enter;
      st_r == ccms_pkg::ST_PREV ##1 st_r == ccms_pkg::ST_ADJ;
   endsequence
   sequence s_read_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   chk_switch_at_frame: assert property ($changed(active_ctx) |-> $past(frame_end))
      else $error("context changed away from frame end");
   chk_snap_no_jpeg: assert property (s_snap_enter |-> !jpeg_en)
      else $error("compression on before adjust done");
   chk_capture_from_adj: assert property ($rose(st_r == ccms_pkg::ST_CAP) |-> $past(st_r) == ccms_pkg::ST_ADJ)
      else $error("capture entered without adjust");
   chk_video_smooth: assert property (ae_smooth == (st_r == ccms_pkg::ST_VID))
      else $error("smooth exposure not tied to video");
   chk_video_exit: assert property (st_r == ccms_pkg::ST_VID && pend_r && frame_end |=> st_r == ccms_pkg::ST_PREV)
      else $error("video did not return to preview");
   chk_cmd_pending: assert property (cmd |=> pend_r)
      else $error("context command lost");
   chk_read_wait: assert property (acc && !hwrite |=> s_read_wait)
      else $error("read answer timing wrong");
   chk_row_gap: assert property (row_strobe && !$past(frame_end) |->
      ((row_rst_addr >= row_rd_addr) ? row_rst_addr - row_rd_addr : row_rst_addr + cur_r.rows - row_rd_addr)
      == $past(app_eff))
      else $error("reset to read gap differs from exposure");
   chk_buffer_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_pix))
      else $error("stalled sample changed");
endmodule // camera_context_mode_sequencer

//--- tb/ccms_host.sv
`timescale 1ns/1ps
`include "ccms_regs.svh"
// host side bus master issuing register traffic
module ccms_host (
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   // bus idle at time zero
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // one word: address phase, then data phase
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      hwdata <= ~wd; // stale data not left on the bus
   endtask
   // context change: snapshot or video per flag
   task ctx_cmd(input logic video, input logic [3:0] nf);
      logic [31:0] rd;
      xfer(1'b1, 32'(`A_CTRL), {23'h0, video, nf, 4'h1}, rd);
   endtask
endmodule // ccms_host

//--- tb/tb.sv
`timescale 1ns/1ps
`include "ccms_regs.svh"
module tb;
   localparam int          FRM = 8 * (8 + 4);
   localparam logic [31:0] CTX = {8'h04, 12'h008, 12'h008};
   logic                   hclk, hresetn, hsel, hwrite, hready, hresp;
   logic                   in_valid, in_ready, out_valid, out_ready;
   logic                   row_strobe, active_ctx, jpeg_en, ae_smooth;
   logic [31:0]            haddr, hwdata, hrdata, rd, wd;
   logic [1:0]             htrans;
   logic [2:0]             hsize;
   logic [11:0]            row_rd_addr, row_rst_addr;
   logic [3:0]             nf;
   ccms_pkg::adc_t         in_pix;
   ccms_pkg::pix_t         out_pix;
   int                     error_cnt, compares, cyc, t0, t1, n, pmode, blk;
   logic [9:0]             q[$];
   logic [31:0]            ra[7] = '{`A_CTRL, `A_CTXA, `A_CTXB, `A_AE, `A_AEWIN, `A_AWB, `A_FLK};
   logic [31:0]            rv[7] = '{`RST_CTRL, `RST_CTXA, `RST_CTXB, `RST_AE, `RST_AEWIN, `RST_AWB, `RST_FLK};

   // clock
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   camera_context_mode_sequencer camera_context_mode_sequencer_i (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hreadyout(hready), .hrdata, .hresp, .in_valid, .in_ready, .in_pix, .out_valid,
      .out_ready, .out_pix, .row_strobe, .row_rd_addr, .row_rst_addr, .active_ctx,
      .jpeg_en, .ae_smooth
   );

   ccms_host ccms_host_i (
      .hclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata
   );

   // compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask

   task tally_and_finish;
      $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // pixel source and sink with queue model
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (in_valid && in_ready && !in_pix.black) q.push_back((in_pix.data > blk) ? in_pix.data - blk : 0);
      if (in_valid && in_ready && in_pix.black) blk = blk + ((int'(in_pix.data) - blk) >>> 3);
      if (out_valid === 1'b1 && out_ready) begin
         chk(q.size() > 0, 1'b1, "output without input");
         if (q.size() > 0) chk(out_pix.data, q.pop_front(), "sample value");
      end
      if (!in_valid || in_ready) begin
         in_valid <= (pmode == 0) ? 1'($urandom) : (pmode == 2);
         in_pix <= {(pmode == 0) && ($urandom % 8 == 0), 10'($urandom)};
      end
      out_ready <= (pmode == 0) ? 1'($urandom) : (pmode == 1);
   end

   // hang guard
   initial begin
      #250000;
      error_cnt++;
      $display("MISMATCH %0t watchdog expired", $time);
      tally_and_finish;
   end

   initial begin
      hresetn = 1'b0;
      in_valid = 1'b0;
      in_pix = '0;
      out_ready = 1'b0;
      pmode = 0;
      cyc = 0;
      t1 = 0;
      rd = $urandom(14);
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         ccms_host_i.xfer(1'b0, ra[i], 32'h0, rd);
         chk(rd, rv[i], "reset value");
      end
      chk(hresp, 1'b0, "response not okay");
      wd = $urandom;
      ccms_host_i.xfer(1'b1, 32'h200, wd, rd);
      ccms_host_i.xfer(1'b1, 32'h3FC, ~wd, rd);
      ccms_host_i.xfer(1'b1, 32'h100, wd, rd);
      ccms_host_i.xfer(1'b0, 32'h200, 32'h0, rd);
      chk(rd, wd, "table low word");
      ccms_host_i.xfer(1'b0, 32'h3FC, 32'h0, rd);
      chk(rd, ~wd, "table high word");
      ccms_host_i.xfer(1'b0, 32'h100, 32'h0, rd);
      chk(rd, 32'h0, "unmapped read");
      ccms_host_i.xfer(1'b1, 32'(`A_CTXA), CTX, rd);
      ccms_host_i.xfer(1'b1, 32'(`A_CTXB), CTX, rd);
      ccms_host_i.xfer(1'b0, 32'(`A_CTXB), 32'h0, rd);
      chk(rd, CTX, "capture set");
      $display("test registers done");
      // snapshots with frame count 0 and 2
      for (int k = 0; k < 2; k++) begin
         nf = 4'(k * 2);
         ccms_host_i.ctx_cmd(1'b0, nf);
         for (n = 0; n < 1000 && active_ctx !== 1'b1; n++) @(posedge hclk);
         t0 = cyc;
         chk(active_ctx, 1'b1, "no switch to capture set");
         if (k > 0) chk((t0 - t1) % FRM, 0, "switch off frame edge");
         for (n = 0; n < 1000 && jpeg_en !== 1'b1; n++) @(posedge hclk);
         chk(cyc - t0, 2 * FRM, "adjust length");
         chk(ae_smooth, 1'b0, "smooth in snapshot");
         t0 = cyc;
         for (n = 0; n < 2000 && jpeg_en !== 1'b0; n++) @(posedge hclk);
         chk(cyc - t0, ((nf == 0) ? 1 : nf) * FRM, "capture length");
         chk(active_ctx, 1'b0, "no return to preview");
         t1 = cyc;
         $display("test snapshot %0d done", k);
      end
      // video start and exit
      ccms_host_i.ctx_cmd(1'b1, 4'h0);
      for (n = 0; n < 1000 && active_ctx !== 1'b1; n++) @(posedge hclk);
      t0 = cyc;
      chk((t0 - t1) % FRM, 0, "video off frame edge");
      chk(ae_smooth, 1'b1, "video not smooth");
      chk(jpeg_en, 1'b0, "compression in video");
      ccms_host_i.xfer(1'b0, 32'(`A_STAT), 32'h0, rd);
      chk(rd[4:0], 5'h15, "video status");
      repeat (3 * FRM) @(posedge hclk);
      chk(active_ctx, 1'b1, "video left early");
      ccms_host_i.ctx_cmd(1'b0, 4'h0);
      for (n = 0; n < 1000 && active_ctx !== 1'b0; n++) @(posedge hclk);
      chk((cyc - t0) % FRM, 0, "exit off frame edge");
      chk(ae_smooth, 1'b0, "smooth after exit");
      $display("test video done");
      // drain, stall and fill, drain
      pmode <= 1;
      repeat (20) @(posedge hclk);
      chk(q.size(), 0, "samples lost");
      pmode <= 2;
      repeat (12) @(posedge hclk);
      chk(in_ready, 1'b0, "buffer full accepted");
      chk(q.size(), 2, "buffer depth");
      pmode <= 1;
      repeat (12) @(posedge hclk);
      chk(q.size(), 0, "buffer not drained");
      $display("test buffer done");
      tally_and_finish;
   end
endmodule // tb
